// ==== eeprom_port_pkg.sv ====
/*
 * Shared constants and carrier types for the three-wire EEPROM access port.
 * Assumes a 20 MHz core clock and an 8-bit core data path.
 */
package eeprom_port_pkg;

    // Location of the access register in the data memory.
    localparam logic [7:0] PIN_ACCESS_OFFSET = 8'h40;
    localparam logic [1:0] PIN_ACCESS_BANK   = 2'h1;

    // Bit positions inside the access register.
    localparam int CS_POS = 4;
    localparam int SK_POS = 5;
    localparam int DI_POS = 6;
    localparam int DO_POS = 7;

    // Value of the stored pin bits after reset.
    localparam logic CS_RESET = 1'h0;
    localparam logic SK_RESET = 1'h0;
    localparam logic DI_RESET = 1'h0;

    // Array geometry and serial field widths.
    localparam int ARRAY_DEPTH  = 256;
    localparam int ADDR_BITS    = 9;
    localparam logic [3:0] ADDR_LAST = 4'h8;
    localparam logic [3:0] OPC_LAST  = 4'h1;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Two-bit opcodes after the start bit.
    localparam logic [1:0] OPC_READ   = 2'h2;
    localparam logic [1:0] OPC_WRITE  = 2'h1;
    localparam logic [1:0] OPC_ERASE  = 2'h3;
    localparam logic [1:0] OPC_GLOBAL = 2'h0;

    // Leading address bits that pick one of the four global instructions.
    localparam logic [1:0] SUB_PROGRAM_ENABLE  = 2'h3;
    localparam logic [1:0] SUB_PROGRAM_DISABLE = 2'h0;
    localparam logic [1:0] SUB_ERASE_ALL       = 2'h2;
    localparam logic [1:0] SUB_FILL_ALL        = 2'h1;

    // Self-timed program cycle; the count rounds up to whole clocks.
    localparam int CLK_PERIOD_NS    = 50;
    localparam int PROGRAM_CYCLE_NS = 5000000;
    localparam int PROGRAM_CYCLES   = (PROGRAM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Kind of self-timed program operation pending or running.
    typedef enum logic [2:0] {
        PK_NONE,
        PK_WRITE,
        PK_ERASE,
        PK_ERASE_ALL,
        PK_FILL_ALL
    } prog_kind_t;

    // One program operation handed to the cell array.
    typedef struct packed {
        prog_kind_t  kind;
        logic [7:0]  addr;
        logic [7:0]  data;
    } prog_op_t;

    // One core access to the data memory as seen by this block.
    typedef struct packed {
        logic        ind_wr;
        logic        ind_rd;
        logic [7:0]  pointer;
        logic [1:0]  bank;
        logic [7:0]  wdata;
    } core_req_t;

endpackage

// ==== eeprom_write_timer.sv ====
/*
 * Self-timed program cycle counter for the EEPROM.
 * Assumes start is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/1ns
module eeprom_write_timer #(
    parameter int CYCLES = eeprom_port_pkg::PROGRAM_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    logic [31:0] cnt_q;   // Cycles left in the running program cycle.
    logic [31:0] cnt_d;   // Next value of the counter.
    logic        done_q;  // One-cycle pulse at the end of a cycle.
    logic        done_d;  // Next value of the end pulse.

    // Count down while busy; a start while busy is ignored by the caller.
    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (start)
        begin
            cnt_d = 32'(CYCLES);
        end
        else if (cnt_q != 32'h0)
        begin
            cnt_d  = cnt_q - 32'h1;
            done_d = (cnt_q == 32'h1);
        end
    end

    // Registers only.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q  <= 32'h0;
            done_q <= 1'b0;
        end
        else if (ce)
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy = (cnt_q != 32'h0);
    assign done = done_q;

endmodule // eeprom_write_timer

// ==== eeprom_cell_array.sv ====
/*
 * The 256-byte EEPROM cell array with single-byte and whole-array updates.
 * Assumes commit is a one-cycle pulse; contents are not touched by reset.
 */
`timescale 1ns/1ns
module eeprom_cell_array (
    input  wire logic                      clk,
    input  wire logic                      ce,
    input  wire logic                      commit,
    input  wire eeprom_port_pkg::prog_op_t op,
    input  wire logic [7:0]                rd_addr,
    output logic [7:0]                     rd_data
);

    logic [7:0] cell_q [eeprom_port_pkg::ARRAY_DEPTH]; // Stored bytes.

    // Each byte decides on its own whether a committed operation hits it.
    genvar gi;
    generate
        for (gi = 0; gi < eeprom_port_pkg::ARRAY_DEPTH; gi++)
        begin : g_cell
            logic [7:0] cell_d; // Next value of this byte.
            always_comb
            begin
                cell_d = cell_q[gi];
                if (commit)
                begin
                    case (op.kind)
                        eeprom_port_pkg::PK_WRITE:
                            if (op.addr == 8'(gi)) cell_d = op.data;
                        eeprom_port_pkg::PK_ERASE:
                            if (op.addr == 8'(gi)) cell_d = eeprom_port_pkg::ERASED_BYTE;
                        eeprom_port_pkg::PK_ERASE_ALL: cell_d = eeprom_port_pkg::ERASED_BYTE;
                        eeprom_port_pkg::PK_FILL_ALL:  cell_d = op.data;
                        default:                       cell_d = cell_q[gi];
                    endcase
                end
            end
            // Nonvolatile storage: no reset, only the clock enable.
            always_ff @(posedge clk)
            begin
                if (ce)
                begin
                    cell_q[gi] <= cell_d;
                end
            end
        end
    endgenerate

    assign rd_data = cell_q[rd_addr];

endmodule // eeprom_cell_array

// ==== eeprom_three_wire_port.sv ====
/*
 * Access register and serial instruction engine of the internal EEPROM.
 * Assumes the core presents indirect accesses through its second pointer as
 * one-cycle strobes on the same clock; there are no pins from outside.
 */
`timescale 1ns/1ns

// Operation
// - Bits 0 to 3 read as zero
// - Bit 4 is the chip select
// - Bit 5 is the shift clock
// - Bit 6 carries serial input bits
// - Bit 7 reads the serial output
// - Read bits appear after each clock rise
// - Output floats unless reading or reporting status
// - Input bit captured on clock rise
// - Register at 40h, bank 1, indirect only
// - Array holds 256 bytes, not mapped
// - Exactly seven serial instructions supported
// - Start bit, two-bit opcode, nine address bits
// - Global group chosen by two address bits
// - Read: dummy zero, then auto-increment bytes
// - Self-timed program cycle; busy low, ready high
module eeprom_three_wire_port #(
    parameter int PROGRAM_CYCLES = eeprom_port_pkg::PROGRAM_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire eeprom_port_pkg::core_req_t req,
    output logic [7:0]                      rdata,
    output logic                            chip_select_bit,
    output logic                            shift_clock_bit,
    output logic                            serial_in_bit,
    output logic                            serial_out_bit,
    output logic                            serial_out_oe,
    output logic                            program_busy
);

    // Instruction engine states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPC,
        ST_ADDR,
        ST_DATA,
        ST_READ,
        ST_DONE
    } state_t;

    state_t                    state_q;    // Engine state.
    state_t                    state_d;    // Next engine state.
    logic                      cs_q;       // Stored chip select bit.
    logic                      cs_d;       // Next chip select bit.
    logic                      sk_q;       // Stored shift clock bit.
    logic                      sk_d;       // Next shift clock bit.
    logic                      di_q;       // Stored serial input bit.
    logic                      di_d;       // Next serial input bit.
    logic [1:0]                opc_q;      // Received opcode.
    logic [1:0]                opc_d;      // Next opcode.
    logic [8:0]                addr_q;     // Received or running address.
    logic [8:0]                addr_d;     // Next address.
    logic [7:0]                data_q;     // Received write data.
    logic [7:0]                data_d;     // Next write data.
    logic [3:0]                cnt_q;      // Bits taken in the current field.
    logic [3:0]                cnt_d;      // Next bit count.
    logic [2:0]                bit_q;      // Bit of the byte being read out.
    logic [2:0]                bit_d;      // Next read bit.
    logic                      do_q;       // Serial output bit while reading.
    logic                      do_d;       // Next serial output bit.
    logic                      rd_oe_q;    // Output driven by a read.
    logic                      rd_oe_d;    // Next read drive.
    logic                      status_q;   // Status report armed.
    logic                      status_d;   // Next status flag.
    logic                      enable_q;   // Program operations allowed.
    logic                      enable_d;   // Next program enable.
    eeprom_port_pkg::prog_kind_t pend_q;   // Operation waiting for select low.
    eeprom_port_pkg::prog_kind_t pend_d;   // Next pending operation.
    eeprom_port_pkg::prog_op_t run_q;      // Operation in the timed cycle.
    eeprom_port_pkg::prog_op_t run_d;      // Next running operation.
    logic [7:0]                rdata_q;    // Registered read data.
    logic [7:0]                rdata_d;    // Next read data.
    logic                      hit;        // Access addresses the register.
    logic                      wr_hit;     // Write to the register.
    logic                      rd_hit;     // Read of the register.
    logic                      sk_rise;    // Shift clock edge from software.
    logic                      cs_fall;    // Select dropped by software.
    logic                      go;         // Start a timed program cycle.
    logic                      done;       // Timed program cycle finished.
    logic                      status_on;  // Output shows busy or ready.
    logic                      do_bit;     // Level of the serial output.
    logic [7:0]                mem_rdata;  // Byte at the read address.
    logic [8:0]                full_addr;  // Address with the newest bit.

    // Decode an indirect access through the second pointer.
    // Bank 1, offset 40h
    assign hit    = (req.pointer == eeprom_port_pkg::PIN_ACCESS_OFFSET)
                    && (req.bank == eeprom_port_pkg::PIN_ACCESS_BANK);
    assign wr_hit = req.ind_wr && hit;
    assign rd_hit = req.ind_rd && hit;

    assign sk_rise   = wr_hit && req.wdata[eeprom_port_pkg::SK_POS] && !sk_q;
    assign cs_fall   = wr_hit && !req.wdata[eeprom_port_pkg::CS_POS] && cs_q;
    assign full_addr = {addr_q[7:0], req.wdata[eeprom_port_pkg::DI_POS]};

    assign status_on = status_q && cs_q;
    assign do_bit    = status_on ? !program_busy : do_q;

    // The engine; every step happens on a software register write.
    always_comb
    begin
        state_d  = state_q;
        cs_d     = cs_q;
        sk_d     = sk_q;
        di_d     = di_q;
        opc_d    = opc_q;
        addr_d   = addr_q;
        data_d   = data_q;
        cnt_d    = cnt_q;
        bit_d    = bit_q;
        do_d     = do_q;
        rd_oe_d  = rd_oe_q;
        status_d = status_q;
        enable_d = enable_q;
        pend_d   = pend_q;
        run_d    = run_q;
        go       = 1'b0;
        if (wr_hit)
        begin
            cs_d = req.wdata[eeprom_port_pkg::CS_POS];
            sk_d = req.wdata[eeprom_port_pkg::SK_POS];
            di_d = req.wdata[eeprom_port_pkg::DI_POS];
        end
        if (cs_fall)
        begin
            // Dropping select ends any instruction and stops a read.
            state_d = ST_IDLE;
            rd_oe_d = 1'b0;
            pend_d  = eeprom_port_pkg::PK_NONE;
            if (state_q == ST_DONE && pend_q != eeprom_port_pkg::PK_NONE
                && enable_q && !program_busy)
            begin
                go          = 1'b1;
                run_d.kind  = pend_q;
                run_d.addr  = addr_q[7:0];
                run_d.data  = data_q;
            end
            // Keep the report armed while the cycle still runs.
            status_d = go || (status_q && program_busy);
        end
        else if (sk_rise && req.wdata[eeprom_port_pkg::CS_POS] && !program_busy)
        begin
            case (state_q)
                ST_IDLE:
                    if (req.wdata[eeprom_port_pkg::DI_POS])
                    begin
                        state_d  = ST_OPC;
                        cnt_d    = 4'h0;
                        status_d = 1'b0;
                    end
                ST_OPC:
                begin
                    opc_d = {opc_q[0], req.wdata[eeprom_port_pkg::DI_POS]};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == eeprom_port_pkg::OPC_LAST)
                    begin
                        state_d = ST_ADDR;
                        cnt_d   = 4'h0;
                    end
                end
                ST_ADDR:
                begin
                    addr_d = full_addr;
                    cnt_d  = cnt_q + 4'h1;
                    if (cnt_q == eeprom_port_pkg::ADDR_LAST)
                    begin
                        cnt_d   = 4'h0;
                        state_d = ST_DONE;
                        case (opc_q)
                            eeprom_port_pkg::OPC_READ:
                            begin
                                state_d = ST_READ;
                                rd_oe_d = 1'b1;
                                do_d    = 1'b0;
                                bit_d   = 3'h0;
                            end
                            eeprom_port_pkg::OPC_WRITE:
                                state_d = ST_DATA;
                            eeprom_port_pkg::OPC_ERASE:
                                pend_d = eeprom_port_pkg::PK_ERASE;
                            default:
                                case (full_addr[8:7])
                                    eeprom_port_pkg::SUB_PROGRAM_ENABLE:  enable_d = 1'b1;
                                    eeprom_port_pkg::SUB_PROGRAM_DISABLE: enable_d = 1'b0;
                                    eeprom_port_pkg::SUB_ERASE_ALL:
                                        pend_d = eeprom_port_pkg::PK_ERASE_ALL;
                                    default:
                                        state_d = ST_DATA;
                                endcase
                        endcase
                    end
                end
                ST_DATA:
                begin
                    data_d = {data_q[6:0], req.wdata[eeprom_port_pkg::DI_POS]};
                    cnt_d  = cnt_q + 4'h1;
                    if (cnt_q == eeprom_port_pkg::DATA_LAST)
                    begin
                        state_d = ST_DONE;
                        pend_d  = (opc_q == eeprom_port_pkg::OPC_WRITE)
                                  ? eeprom_port_pkg::PK_WRITE : eeprom_port_pkg::PK_FILL_ALL;
                    end
                end
                ST_READ:
                begin
                    do_d = mem_rdata[3'h7 - bit_q];
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7)
                    begin
                        addr_d = {1'b0, addr_q[7:0] + 8'h1};
                    end
                end
                ST_DONE:
                    // Extra clocks after a complete instruction are ignored.
                    state_d = ST_DONE;
                default:
                    state_d = ST_IDLE;
            endcase
        end
    end

    // Read data is built the cycle the read strobe arrives.
    always_comb
    begin
        rdata_d = rdata_q;
        if (rd_hit)
        begin
            rdata_d = {serial_out_oe && do_bit, di_q, sk_q, cs_q, 4'h0};
        end
    end

    // Registers only.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q  <= ST_IDLE;
            cs_q     <= eeprom_port_pkg::CS_RESET;
            sk_q     <= eeprom_port_pkg::SK_RESET;
            di_q     <= eeprom_port_pkg::DI_RESET;
            opc_q    <= 2'h0;
            addr_q   <= 9'h000;
            data_q   <= 8'h00;
            cnt_q    <= 4'h0;
            bit_q    <= 3'h0;
            do_q     <= 1'b0;
            rd_oe_q  <= 1'b0;
            status_q <= 1'b0;
            enable_q <= 1'b0;
            pend_q   <= eeprom_port_pkg::PK_NONE;
            run_q    <= '0;
            rdata_q  <= 8'h00;
        end
        else if (ce)
        begin
            state_q  <= state_d;
            cs_q     <= cs_d;
            sk_q     <= sk_d;
            di_q     <= di_d;
            opc_q    <= opc_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            cnt_q    <= cnt_d;
            bit_q    <= bit_d;
            do_q     <= do_d;
            rd_oe_q  <= rd_oe_d;
            status_q <= status_d;
            enable_q <= enable_d;
            pend_q   <= pend_d;
            run_q    <= run_d;
            rdata_q  <= rdata_d;
        end
    end

    eeprom_write_timer #(
        .CYCLES (PROGRAM_CYCLES)
    ) u_timer (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .start (go),
        .busy  (program_busy),
        .done  (done)
    );

    eeprom_cell_array u_cells (
        .clk     (clk),
        .ce      (ce),
        .commit  (done),
        .op      (run_q),
        .rd_addr (addr_q[7:0]),
        .rd_data (mem_rdata)
    );

    assign rdata           = rdata_q;
    assign chip_select_bit = cs_q;
    assign shift_clock_bit = sk_q;
    assign serial_in_bit   = di_q;
    assign serial_out_oe   = rd_oe_q || status_on;
    assign serial_out_bit  = serial_out_oe && do_bit;

    // Last address bit of a read taken.
    sequence s_read_addr_end;
        state_q == ST_ADDR && cnt_q == eeprom_port_pkg::ADDR_LAST && opc_q == eeprom_port_pkg::OPC_READ
        && sk_rise && req.wdata[eeprom_port_pkg::CS_POS] && !program_busy && ce;
    endsequence

    a_low_nibble_zero: assert property (@(posedge clk) disable iff (rst) rdata_q[3:0] == 4'h0)
        else $error("Low nibble of the access register is not zero.");
    a_select_follows: assert property (@(posedge clk) disable iff (rst)
        wr_hit && ce |=> chip_select_bit == $past(req.wdata[eeprom_port_pkg::CS_POS]))
        else $error("Chip select does not follow bit 4.");
    a_clock_from_write: assert property (@(posedge clk) disable iff (rst)
        $rose(shift_clock_bit) |-> $past(wr_hit))
        else $error("Shift clock rose without a register write.");
    a_in_bit_follows: assert property (@(posedge clk) disable iff (rst)
        wr_hit && ce |=> serial_in_bit == $past(req.wdata[eeprom_port_pkg::DI_POS]))
        else $error("Serial input bit does not follow bit 6.");
    a_out_readback: assert property (@(posedge clk) disable iff (rst)
        rd_hit && ce |=> rdata_q[eeprom_port_pkg::DO_POS] == $past(serial_out_bit))
        else $error("Bit 7 does not return the serial output.");
    a_read_drives: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_READ && sk_rise && req.wdata[eeprom_port_pkg::CS_POS] && ce && !program_busy |=> serial_out_oe)
        else $error("Read bit not driven after a clock rise.");
    a_float_else: assert property (@(posedge clk) disable iff (rst)
        serial_out_oe |-> state_q == ST_READ || status_q)
        else $error("Serial output driven outside a read or status report.");
    a_dummy_zero: assert property (@(posedge clk) disable iff (rst)
        s_read_addr_end |=> serial_out_oe && !serial_out_bit)
        else $error("Read did not start with a dummy zero.");
    a_decode_only: assert property (@(posedge clk) disable iff (rst)
        req.ind_wr && !hit |=> $stable(chip_select_bit) && $stable(shift_clock_bit))
        else $error("Access outside bank 1 offset 40h changed the register.");
    a_busy_refuses: assert property (@(posedge clk) disable iff (rst)
        program_busy && state_q == ST_IDLE |=> state_q == ST_IDLE)
        else $error("Instruction accepted during a program cycle.");

endmodule // eeprom_three_wire_port

// ==== host_model.sv ====
/* Core software side: reaches the pin register through the indirect port.
   Assumes clk is the core clock and rdata is the design's read data. */
`timescale 1ns/1ns
module host_model (
    input  wire logic                  clk,
    input  wire logic [7:0]            rdata,
    output eeprom_port_pkg::core_req_t req
);
    // One access every four clocks, so a shift edge pair lasts 400 ns.
    // The caller orders the bits, the select and the setup.
    task automatic acc(input logic w, input logic [7:0] p, input logic [1:0] b,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1 req = '{w, !w, p, b, d};
        @(posedge clk);
        // A released bus shows the inverse, so stale values never match.
        #1 req = '{1'b0, 1'b0, ~p, ~b, ~d};
        repeat (2) @(posedge clk);
        #1 q = rdata;
    endtask
    initial req = '0;
endmodule // host_model

// ==== tb_top.sv ====
/* Self-checking bench for the EEPROM pin register and serial engine.
   Assumes the short program cycle set below. */
`timescale 1ns/1ns
module tb_top;
    logic clk, rst, ce, cs, sk, di, dout, oe, busy;
    logic [7:0] rdata, q;
    logic [15:0] got;
    int errors, n_compared;
    eeprom_port_pkg::core_req_t req;
    // Rows: pointer, bank, write data, expected readback.
    logic [7:0] rows [6][4] = '{'{8'h40, 8'h01, 8'h1F, 8'h10}, '{8'h40, 8'h01, 8'h2F, 8'h20},
        '{8'h40, 8'h01, 8'h40, 8'h40}, '{8'h40, 8'h00, 8'h10, 8'h40},
        '{8'h41, 8'h01, 8'h10, 8'h40}, '{8'h40, 8'h01, 8'h00, 8'h00}};
    host_model host (.clk(clk), .rdata(rdata), .req(req));
    eeprom_three_wire_port #(.PROGRAM_CYCLES(20)) dut (.clk(clk), .rst(rst), .ce(ce),
        .req(req), .rdata(rdata), .chip_select_bit(cs), .shift_clock_bit(sk),
        .serial_in_bit(di), .serial_out_bit(dout), .serial_out_oe(oe), .program_busy(busy));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        host.acc(1, 8'h40, 2'h1, d, q);
    endtask
    // Data before clock
    // Each bit is set with the clock low, then the clock is raised.
    task automatic send(input logic [19:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            wr({1'b0, v[i], 2'b01, 4'h0});
            wr({1'b0, v[i], 2'b11, 4'h0});
        end
    endtask
    initial
    begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // Watchdog: the run needs about 750 clocks.
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        finish_test();
    end
    initial
    begin
        rst = 1;
        ce = 1;
        repeat (6) @(posedge clk);
        #1 rst = 0;
        chk("reset", {rdata, 3'h0, cs, sk, di, oe, busy}, 16'h0);
        foreach (rows[i])
        begin
            host.acc(1, rows[i][0], rows[i][1][1:0], rows[i][2], q);
            host.acc(0, 8'h40, 2'h1, 8'h00, q);
            chk("reg", {q, 1'b0, di, sk, cs, 4'h0}, {rows[i][3], rows[i][3]});
        end
        send(20'h980, 12);
        wr(8'h00);
        send(20'h880A5, 20);
        wr(8'h00);
        chk("busy", {15'h0, busy}, 16'h1);
        wr(8'h10);
        host.acc(0, 8'h40, 2'h1, 8'h00, q);
        chk("status", {q, 6'h0, dout, oe}, 16'h1001);
        // Busy is looked at just after the edge, once it has settled.
        for (int i = 0; i < 100 && busy !== 1'b0; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk("done", {15'h0, busy}, 16'h0);
        host.acc(0, 8'h40, 2'h1, 8'h00, q);
        chk("ready", {7'h0, dout, q}, 16'h190);
        send(20'hC03, 12);
        host.acc(0, 8'h40, 2'h1, 8'h00, q);
        chk("dummy", {q, 6'h0, dout, oe}, 16'h7001);
        got = 0;
        for (int i = 0; i < 16; i++)
        begin
            send(20'h0, 1);
            host.acc(0, 8'h40, 2'h1, 8'h00, q);
            got = {got[14:0], q[7]};
        end
        chk("read", got, 16'hA5A5);
        wr(8'h00);
        chk("float", {14'h0, dout, oe}, 16'h0);
        // Clock enable low freezes the register, so this write is lost.
        ce = 0;
        wr(8'h10);
        chk("freeze", {15'h0, cs}, 16'h0);
        ce = 1;
        // A reset in mid-run clears the pins and the program enable.
        wr(8'h50);
        rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        chk("reset2", {rdata, 3'h0, cs, sk, di, oe, busy}, 16'h0);
        // Erase-all without a fresh enable must not start a program cycle.
        send(20'h900, 12);
        wr(8'h00);
        chk("refused", {15'h0, busy}, 16'h0);
        finish_test();
    end
endmodule // tb_top
